// ---- pkg/cct_params.svh ----
`ifndef CCT_PARAMS_SVH
`define CCT_PARAMS_SVH
// ==========================================
// array geometry
`define CCT_BLOCKS 8
`define CCT_IDX_W 3
`define CCT_DATA_W 32
`define CCT_L1_WAYS 4
`define CCT_WAY_W 2
// ==========================================
// tag encodings {valid, dirty, shared}
`define CCT_TAG_INVALID 3'h0
`define CCT_TAG_CLEAN 3'h4
`define CCT_TAG_CLEAN_SHARED 3'h5
`define CCT_TAG_DIRTY 3'h6
`define CCT_TAG_DIRTY_SHARED 3'h7
// ==========================================
// probe next-state codes
`define CCT_PN_NO_CHANGE 3'h0
`define CCT_PN_CLEAN 3'h1
`define CCT_PN_CLEAN_SHARED 3'h2
`define CCT_PN_SHARE_KEEP_DIRTY 3'h3
`define CCT_PN_SHARE_DROP_DIRTY 3'h4
// ==========================================
// system data control response codes
`define CCT_RSP_FILL_CLEAN 3'h0
`define CCT_RSP_FILL_DIRTY 3'h1
`define CCT_RSP_FILL_SHARED 3'h2
`define CCT_RSP_FILL_DIRTY_SHARED 3'h3
`define CCT_RSP_FILL_ERROR 3'h4
`define CCT_RSP_OWNERSHIP_GRANT 3'h5
`define CCT_RSP_OWNERSHIP_REFUSE 3'h6
// ==========================================
// data reset value and fill-error pattern
`define CCT_DATA_RST 32'h0000_0000
`define CCT_DATA_ONES 32'hFFFF_FFFF
`endif

// ---- pkg/cct_pkg.sv ----
`include "cct_params.svh"
package cct_pkg;
	// ==========================================
	// per-block tag: three bits encode five states
	typedef struct packed {
		logic valid;
		logic dirty;
		logic shared;
	} cct_tag_t;
	typedef logic [`CCT_IDX_W-1:0] cct_idx_t;
	typedef logic [`CCT_DATA_W-1:0] cct_data_t;
	typedef logic [2:0] cct_code_t;
	// stores may only update an exclusive dirty copy
	function automatic logic cct_writable(input cct_tag_t t);
		cct_writable = (t == cct_tag_t'(`CCT_TAG_DIRTY));
	endfunction
endpackage

// ---- pkg/cct_ns_if.sv ----
`timescale 1ns/1ns
// carries one tag update request to the next-state decoder
interface cct_ns_if;
	import cct_pkg::*;
	cct_tag_t curTag; // tag before the update
	logic isProbe; // probe, else data-control response
	cct_code_t probeCode; // probe next-state code
	cct_code_t respCode; // response code
	cct_tag_t nextTag; // tag after the update
	logic loadData; // write supplied data into the block
	logic loadOnes; // write all-ones into the block
	logic failStc; // pending store-conditional fails
	logic passStc; // pending store-conditional may proceed
	modport core (output curTag, isProbe, probeCode, respCode,
		input nextTag, loadData, loadOnes, failStc, passStc);
	modport decode (input curTag, isProbe, probeCode, respCode,
		output nextTag, loadData, loadOnes, failStc, passStc);
endinterface

// ---- core/cct_next_state.sv ----
`timescale 1ns/1ns
`include "cct_params.svh"
module cct_next_state (
	cct_ns_if.decode ns
);
	import cct_pkg::*;
	// ==========================================
	// next-state decode
	// pure combinational so probe and fill rules settle in one cycle
	always_comb begin
		ns.nextTag = ns.curTag;
		ns.loadData = 1'b0;
		ns.loadOnes = 1'b0;
		ns.failStc = 1'b0;
		ns.passStc = 1'b0;
		if (ns.isProbe) begin
			// a miss never changes anything
			if (ns.curTag.valid) begin
				unique case (ns.probeCode)
					`CCT_PN_NO_CHANGE: ns.nextTag = ns.curTag;
					`CCT_PN_CLEAN: ns.nextTag = cct_tag_t'(`CCT_TAG_CLEAN);
					`CCT_PN_CLEAN_SHARED: begin
						ns.nextTag = cct_tag_t'(`CCT_TAG_CLEAN_SHARED);
					end
					`CCT_PN_SHARE_KEEP_DIRTY: begin
						// dirty bit picks the shared flavour
						ns.nextTag = ns.curTag.dirty ? cct_tag_t'(`CCT_TAG_DIRTY_SHARED) :
							cct_tag_t'(`CCT_TAG_CLEAN_SHARED);
					end
					`CCT_PN_SHARE_DROP_DIRTY: begin
						// only the exclusive dirty copy is invalidated here; dirty/shared drops to clean/shared
						if (ns.curTag == cct_tag_t'(`CCT_TAG_DIRTY)) begin
							ns.nextTag = cct_tag_t'(`CCT_TAG_INVALID);
						end else if (ns.curTag != cct_tag_t'(`CCT_TAG_CLEAN_SHARED)) begin
							ns.nextTag = cct_tag_t'(`CCT_TAG_CLEAN_SHARED);
						end
					end
					default: ns.nextTag = ns.curTag; // undefined codes act as no change
				endcase
			end
		end else begin
			// system decides; the block obeys whatever arrives
			unique case (ns.respCode)
				`CCT_RSP_FILL_CLEAN: begin
					ns.nextTag = cct_tag_t'(`CCT_TAG_CLEAN);
					ns.loadData = 1'b1;
				end
				`CCT_RSP_FILL_DIRTY: begin
					ns.nextTag = cct_tag_t'(`CCT_TAG_DIRTY);
					ns.loadData = 1'b1;
				end
				`CCT_RSP_FILL_SHARED: begin
					ns.nextTag = cct_tag_t'(`CCT_TAG_CLEAN_SHARED);
					ns.loadData = 1'b1;
				end
				`CCT_RSP_FILL_DIRTY_SHARED: begin
					ns.nextTag = cct_tag_t'(`CCT_TAG_DIRTY_SHARED);
					ns.loadData = 1'b1;
				end
				`CCT_RSP_FILL_ERROR: begin
					ns.nextTag = cct_tag_t'(`CCT_TAG_INVALID);
					ns.loadOnes = 1'b1;
				end
				`CCT_RSP_OWNERSHIP_GRANT: begin
					ns.nextTag = cct_tag_t'(`CCT_TAG_DIRTY);
					ns.passStc = 1'b1;
				end
				`CCT_RSP_OWNERSHIP_REFUSE: begin
					ns.nextTag = ns.curTag;
					ns.failStc = 1'b1;
				end
				default: ns.nextTag = ns.curTag; // unused code, ignored
			endcase
		end
	end
endmodule

// ---- core/cct_tracker.sv ----
`timescale 1ns/1ns
`include "cct_params.svh"
module cct_tracker (
	input wire logic core_clk,
	input wire logic arst_n,
	// probe port
	input wire logic probeValid,
	input wire cct_pkg::cct_idx_t probeIndex,
	input wire cct_pkg::cct_code_t probeNext,
	output logic probeDone,
	output logic probeHit,
	output cct_pkg::cct_tag_t probeState,
	// system_data_control_response port
	input wire logic respValid,
	input wire cct_pkg::cct_idx_t respIndex,
	input wire cct_pkg::cct_code_t respCode,
	input wire cct_pkg::cct_data_t respData,
	output logic respDone,
	output cct_pkg::cct_tag_t respState,
	output logic stcFail,
	output logic stcPass,
	// store_conditional arming
	input wire logic stcArmValid,
	input wire cct_pkg::cct_idx_t stcArmIndex,
	// store port
	input wire logic storeValid,
	input wire cct_pkg::cct_idx_t storeIndex,
	input wire cct_pkg::cct_data_t storeData,
	output logic storeGrant,
	output logic storeDeny,
	// eviction port
	input wire logic evictValid,
	input wire cct_pkg::cct_idx_t evictIndex,
	output logic evictDone,
	output logic writebackValid,
	output cct_pkg::cct_data_t writebackData,
	// data cache allocation
	input wire logic l1AllocValid,
	input wire logic [`CCT_WAY_W-1:0] l1AllocWay,
	input wire cct_pkg::cct_idx_t l1AllocIndex,
	output logic [`CCT_L1_WAYS-1:0] l1Valid,
	// state lookup
	input wire cct_pkg::cct_idx_t lookupIndex,
	output cct_pkg::cct_tag_t lookupState,
	output cct_pkg::cct_data_t lookupData
);
	import cct_pkg::*;

	// ==========================================
	// storage
	cct_tag_t tagArr_reg [`CCT_BLOCKS]; // second-level tags
	cct_data_t dataArr_reg [`CCT_BLOCKS]; // block data
	logic [`CCT_BLOCKS-1:0] stcPend_reg; // armed store-conditionals
	logic [`CCT_L1_WAYS-1:0] l1Valid_reg; // data cache ways
	cct_idx_t l1Idx_reg [`CCT_L1_WAYS]; // block each way mirrors

	// ==========================================
	// arbitration
	// one tag change per cycle; probes first so the system's
	// serialization order is never overtaken by local traffic
	logic respTake; // response owns this cycle
	logic evictTake; // eviction owns this cycle
	logic storeTake; // store owns this cycle
	assign respTake = respValid && !probeValid;
	assign evictTake = evictValid && !probeValid && !respValid;
	assign storeTake = storeValid && !probeValid && !respValid && !evictValid;

	cct_tag_t curProbeTag; // tag seen by the probe
	cct_tag_t curRespTag; // tag seen by the response
	cct_tag_t curEvictTag; // tag seen by the eviction
	cct_tag_t curStoreTag; // tag seen by the store
	assign curProbeTag = tagArr_reg[probeIndex];
	assign curRespTag = tagArr_reg[respIndex];
	assign curEvictTag = tagArr_reg[evictIndex];
	assign curStoreTag = tagArr_reg[storeIndex];

	// ==========================================
	// next-state decoder
	cct_ns_if nsBus ();
	assign nsBus.curTag = probeValid ? curProbeTag : curRespTag;
	assign nsBus.isProbe = probeValid;
	assign nsBus.probeCode = probeNext;
	assign nsBus.respCode = respCode;

	cct_next_state uDecode (
		.ns(nsBus.decode)
	);

	// ==========================================
	// which block changes this cycle, and how
	logic updEn; // a tag is rewritten
	cct_idx_t updIdx; // its index
	cct_tag_t updTag; // its new value
	logic storeOk; // store may update data
	assign storeOk = storeTake && cct_writable(curStoreTag);
	always_comb begin
		updEn = 1'b0;
		updIdx = probeIndex;
		updTag = nsBus.nextTag;
		if (probeValid) begin
			updEn = 1'b1;
		end else if (respTake) begin
			updEn = 1'b1;
			updIdx = respIndex;
		end else if (evictTake) begin
			// leaving the cache means holding no copy at all
			updEn = 1'b1;
			updIdx = evictIndex;
			updTag = cct_tag_t'(`CCT_TAG_INVALID);
		end
	end

	// block goes invalid: data cache copies must go with it
	logic killEn; // invalidation this cycle
	assign killEn = updEn && !updTag.valid;

	// ==========================================
	// tag array
	// no instruction cache state lives here: probes only touch
	// data tags, code coherence is the software barrier's job
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < `CCT_BLOCKS; i++) begin
				tagArr_reg[i] <= cct_tag_t'(`CCT_TAG_INVALID);
			end
		end else if (updEn) begin
			tagArr_reg[updIdx] <= updTag;
		end
	end

	// ==========================================
	// data array
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < `CCT_BLOCKS; i++) begin
				dataArr_reg[i] <= `CCT_DATA_RST;
			end
		end else if (respTake && nsBus.loadData) begin
			dataArr_reg[respIndex] <= respData;
		end else if (respTake && nsBus.loadOnes) begin
			dataArr_reg[respIndex] <= `CCT_DATA_ONES;
		end else if (storeOk) begin
			dataArr_reg[storeIndex] <= storeData;
		end
	end

	// ==========================================
	// store-conditional bookkeeping
	// arming wins over a same-cycle resolution of the same index;
	// a resolution on the armed index consumes it
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			stcPend_reg <= '0;
		end else begin
			for (int i = 0; i < `CCT_BLOCKS; i++) begin
				if (stcArmValid && stcArmIndex == cct_idx_t'(i)) begin
					stcPend_reg[i] <= 1'b1;
				end else if (respTake && respIndex == cct_idx_t'(i) &&
					(nsBus.failStc || nsBus.passStc)) begin
					stcPend_reg[i] <= 1'b0;
				end
			end
		end
	end

	// ==========================================
	// data cache ways kept inside the second level
	// allocation is refused for a block that is absent or dying now
	logic allocOk; // allocation accepted
	assign allocOk = l1AllocValid && tagArr_reg[l1AllocIndex].valid &&
		!(killEn && updIdx == l1AllocIndex);
	generate
		for (genvar w = 0; w < `CCT_L1_WAYS; w++) begin : gWay
			always_ff @(posedge core_clk or negedge arst_n) begin
				if (!arst_n) begin
					l1Valid_reg[w] <= 1'b0;
					l1Idx_reg[w] <= '0;
				end else if (allocOk && l1AllocWay == `CCT_WAY_W'(w)) begin
					l1Valid_reg[w] <= 1'b1;
					l1Idx_reg[w] <= l1AllocIndex;
				end else if (killEn && l1Idx_reg[w] == updIdx) begin
					l1Valid_reg[w] <= 1'b0;
				end
			end
		end
	endgenerate

	// ==========================================
	// probe answers
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			probeDone <= 1'b0;
			probeHit <= 1'b0;
			probeState <= cct_tag_t'(`CCT_TAG_INVALID);
		end else begin
			probeDone <= probeValid;
			probeHit <= probeValid && curProbeTag.valid;
			probeState <= probeValid ? nsBus.nextTag : probeState;
		end
	end

	// ==========================================
	// response answers
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			respDone <= 1'b0;
			respState <= cct_tag_t'(`CCT_TAG_INVALID);
			stcFail <= 1'b0;
			stcPass <= 1'b0;
		end else begin
			respDone <= respTake;
			respState <= respTake ? nsBus.nextTag : respState;
			stcFail <= respTake && nsBus.failStc && stcPend_reg[respIndex];
			stcPass <= respTake && nsBus.passStc && stcPend_reg[respIndex];
		end
	end

	// ==========================================
	// store answers
	// dirty/shared is readable but not writable; the core must
	// ask the system for ownership first
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			storeGrant <= 1'b0;
			storeDeny <= 1'b0;
		end else begin
			storeGrant <= storeOk;
			storeDeny <= storeTake && !storeOk;
		end
	end

	// ==========================================
	// eviction and writeback
	// only dirty copies cost a memory write; clean ones just vanish
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			evictDone <= 1'b0;
			writebackValid <= 1'b0;
			writebackData <= `CCT_DATA_RST;
		end else begin
			evictDone <= evictTake;
			writebackValid <= evictTake && curEvictTag.dirty;
			writebackData <= evictTake ? dataArr_reg[evictIndex] : writebackData;
		end
	end

	// ==========================================
	// status outputs
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			l1Valid <= '0;
			lookupState <= cct_tag_t'(`CCT_TAG_INVALID);
			lookupData <= `CCT_DATA_RST;
		end else begin
			l1Valid <= l1Valid_reg;
			lookupState <= tagArr_reg[lookupIndex];
			lookupData <= dataArr_reg[lookupIndex];
		end
	end

	// ==========================================
	// assertions
	AST_PROBE_CLEAN: assert property (@(posedge core_clk) disable iff (!arst_n)
		probeValid && curProbeTag.valid && probeNext == `CCT_PN_CLEAN
		|=> probeDone && probeState == cct_tag_t'(`CCT_TAG_CLEAN))
		else $error("clean probe did not give clean");
	AST_PROBE_CSHARED: assert property (@(posedge core_clk) disable iff (!arst_n)
		probeValid && curProbeTag.valid && probeNext == `CCT_PN_CLEAN_SHARED
		|=> probeState == cct_tag_t'(`CCT_TAG_CLEAN_SHARED))
		else $error("clean/shared probe wrong");
	AST_PROBE_NOCHG: assert property (@(posedge core_clk) disable iff (!arst_n)
		probeValid && probeNext == `CCT_PN_NO_CHANGE
		|=> probeState == $past(curProbeTag))
		else $error("no-change probe altered tag");
	AST_PROBE_KEEP: assert property (@(posedge core_clk) disable iff (!arst_n)
		probeValid && curProbeTag.valid && curProbeTag.dirty &&
		probeNext == `CCT_PN_SHARE_KEEP_DIRTY
		|=> probeState == cct_tag_t'(`CCT_TAG_DIRTY_SHARED))
		else $error("keep-dirty share wrong");
	AST_PROBE_DROP: assert property (@(posedge core_clk) disable iff (!arst_n)
		probeValid && curProbeTag == cct_tag_t'(`CCT_TAG_DIRTY) &&
		probeNext == `CCT_PN_SHARE_DROP_DIRTY
		|=> probeHit && !probeState.valid ##1 !tagArr_reg[$past(probeIndex, 2)].valid)
		else $error("drop-dirty share did not invalidate");
	AST_FILL_ERR: assert property (@(posedge core_clk) disable iff (!arst_n)
		respTake && respCode == `CCT_RSP_FILL_ERROR
		|=> respState == cct_tag_t'(`CCT_TAG_INVALID) &&
		dataArr_reg[$past(respIndex)] == `CCT_DATA_ONES)
		else $error("fill error not applied");
	AST_FILL_DIRTY: assert property (@(posedge core_clk) disable iff (!arst_n)
		respTake && respCode == `CCT_RSP_FILL_DIRTY
		|=> respDone && dataArr_reg[$past(respIndex)] == $past(respData))
		else $error("fill dirty data not loaded");
	AST_GRANT: assert property (@(posedge core_clk) disable iff (!arst_n)
		respTake && respCode == `CCT_RSP_OWNERSHIP_GRANT
		|=> respState == cct_tag_t'(`CCT_TAG_DIRTY))
		else $error("grant did not mark dirty");
	AST_REFUSE: assert property (@(posedge core_clk) disable iff (!arst_n)
		respTake && respCode == `CCT_RSP_OWNERSHIP_REFUSE && stcPend_reg[respIndex]
		|=> stcFail && !stcPass && respState == $past(curRespTag))
		else $error("refuse handling wrong");
	AST_STORE_DENY: assert property (@(posedge core_clk) disable iff (!arst_n)
		storeTake && curStoreTag == cct_tag_t'(`CCT_TAG_DIRTY_SHARED)
		|=> storeDeny && !storeGrant)
		else $error("store to dirty/shared allowed");
	AST_WRITEBACK: assert property (@(posedge core_clk) disable iff (!arst_n)
		evictTake |=> writebackValid == $past(curEvictTag.dirty))
		else $error("writeback choice wrong");
	generate
		for (genvar w = 0; w < `CCT_L1_WAYS; w++) begin : gSub
			AST_SUBSET: assert property (@(posedge core_clk) disable iff (!arst_n)
				l1Valid_reg[w] |-> tagArr_reg[l1Idx_reg[w]].valid)
				else $error("data cache way outside second level");
		end
	endgenerate
	COV_PROBE_DROP: cover property (@(posedge core_clk) disable iff (!arst_n)
		probeValid && probeNext == `CCT_PN_SHARE_DROP_DIRTY && curProbeTag.dirty);
	COV_REFUSE_STC: cover property (@(posedge core_clk) disable iff (!arst_n)
		respTake && nsBus.failStc && stcPend_reg[respIndex]);
	COV_DIRTY_EVICT: cover property (@(posedge core_clk) disable iff (!arst_n)
		evictTake && curEvictTag.dirty);
endmodule

// ---- sim/cct_sys_model.sv ----
`timescale 1ns/1ns
// ==========================================
// system coherence controller stand-in
module cct_sys_model (
	input wire logic core_clk,
	output logic probeValid,
	output cct_pkg::cct_idx_t probeIndex,
	output cct_pkg::cct_code_t probeNext,
	output logic respValid,
	output cct_pkg::cct_idx_t respIndex,
	output cct_pkg::cct_code_t respCode,
	output cct_pkg::cct_data_t respData
);
	import cct_pkg::*;
	// idle lines start at zero before the first request
	initial begin
		probeValid = 1'b0;
		probeIndex = 3'h0;
		probeNext = 3'h0;
		respValid = 1'b0;
		respIndex = 3'h0;
		respCode = 3'h0;
		respData = 32'h0000_0000;
	end
	// ==========================================
	// probe issue: one request at a time, so no block sees two changes at once
	task automatic probe(input cct_idx_t idx, input cct_code_t code, input int gap);
		repeat (gap) @(negedge core_clk);
		@(negedge core_clk);
		probeValid = 1'b1;
		probeIndex = idx;
		probeNext = code;
		@(posedge core_clk);
		@(negedge core_clk);
		probeValid = 1'b0;
		// released lines flip so stale values never look valid
		probeIndex = ~idx;
		probeNext = ~code;
	endtask
	// ==========================================
	// data-control response: the system alone picks the outcome
	task automatic resp(input cct_idx_t idx, input cct_code_t code, input cct_data_t data,
		input int gap);
		repeat (gap) @(negedge core_clk);
		@(negedge core_clk);
		respValid = 1'b1;
		respIndex = idx;
		respCode = code;
		respData = data;
		@(posedge core_clk);
		@(negedge core_clk);
		respValid = 1'b0;
		respIndex = ~idx;
		respCode = ~code;
		respData = ~data;
	endtask
endmodule

// ---- sim/tb.sv ----
`timescale 1ns/1ns
`include "cct_params.svh"
// ==========================================
// self-checking bench for the coherence tracker
module tb;
	import cct_pkg::*;
	logic core_clk, arst_n, probeDone, probeHit, respDone, stcFail, stcPass;
	logic probeValid, respValid, stcArmValid, storeValid, evictValid, l1AllocValid;
	logic storeGrant, storeDeny, evictDone, writebackValid;
	cct_idx_t probeIndex, respIndex, stcArmIndex, storeIndex, evictIndex, l1AllocIndex;
	cct_idx_t lookupIndex;
	cct_code_t probeNext, respCode;
	cct_data_t respData, storeData, writebackData, lookupData;
	cct_tag_t probeState, respState, lookupState;
	logic [`CCT_WAY_W-1:0] l1AllocWay;
	logic [`CCT_L1_WAYS-1:0] l1Valid;
	int n_mismatch = 0;
	int num_checks = 0;
	int cycles = 0;
	// ==========================================
	// clock, time-zero values and hang guard
	initial core_clk = 1'b0;
	always #20 core_clk = ~core_clk;
	initial begin
		arst_n = 1'b0;
		{stcArmValid, storeValid, evictValid, l1AllocValid} = 4'h0;
		{stcArmIndex, storeIndex, evictIndex, l1AllocIndex, lookupIndex} = 15'h0000;
		storeData = 32'h0000_0000;
		l1AllocWay = 2'h0;
	end
	// ceiling well above the roughly 350 cycles the scenarios need
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	cct_sys_model sys (.core_clk(core_clk), .probeValid(probeValid), .probeIndex(probeIndex),
		.probeNext(probeNext), .respValid(respValid), .respIndex(respIndex),
		.respCode(respCode), .respData(respData));
	cct_tracker dut (.core_clk(core_clk), .arst_n(arst_n), .probeValid(probeValid),
		.probeIndex(probeIndex), .probeNext(probeNext), .probeDone(probeDone),
		.probeHit(probeHit), .probeState(probeState), .respValid(respValid),
		.respIndex(respIndex), .respCode(respCode), .respData(respData),
		.respDone(respDone), .respState(respState), .stcFail(stcFail), .stcPass(stcPass),
		.stcArmValid(stcArmValid), .stcArmIndex(stcArmIndex), .storeValid(storeValid),
		.storeIndex(storeIndex), .storeData(storeData), .storeGrant(storeGrant),
		.storeDeny(storeDeny), .evictValid(evictValid), .evictIndex(evictIndex),
		.evictDone(evictDone), .writebackValid(writebackValid),
		.writebackData(writebackData), .l1AllocValid(l1AllocValid),
		.l1AllocWay(l1AllocWay), .l1AllocIndex(l1AllocIndex), .l1Valid(l1Valid),
		.lookupIndex(lookupIndex), .lookupState(lookupState), .lookupData(lookupData));
	// ==========================================
	// shared helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// tag that each fill code other than fill error leaves behind
	function automatic logic [2:0] fill_tag(input int c);
		case (c)
			0: fill_tag = `CCT_TAG_CLEAN;
			1: fill_tag = `CCT_TAG_DIRTY;
			2: fill_tag = `CCT_TAG_CLEAN_SHARED;
			default: fill_tag = `CCT_TAG_DIRTY_SHARED;
		endcase
	endfunction
	// expected tag after a probe hit on a valid block
	function automatic logic [2:0] probe_tag(input logic [2:0] p, input int c);
		case (c)
			1: probe_tag = `CCT_TAG_CLEAN;
			2: probe_tag = `CCT_TAG_CLEAN_SHARED;
			3: probe_tag = {2'b11, 1'b1} & {1'b1, p[1], 1'b1};
			4: probe_tag = (p == `CCT_TAG_DIRTY) ? `CCT_TAG_INVALID : `CCT_TAG_CLEAN_SHARED;
			default: probe_tag = p; // undefined codes leave the tag alone
		endcase
	endfunction
	// lookup is registered, so the answer shows one cycle on
	task automatic peek(input cct_idx_t idx);
		@(negedge core_clk);
		lookupIndex = idx;
		@(posedge core_clk);
		@(negedge core_clk);
	endtask
	task automatic store(input cct_idx_t idx, input cct_data_t d);
		@(negedge core_clk);
		storeValid = 1'b1;
		storeIndex = idx;
		storeData = d;
		@(posedge core_clk);
		@(negedge core_clk);
		storeValid = 1'b0;
	endtask
	task automatic evict(input cct_idx_t idx);
		@(negedge core_clk);
		evictValid = 1'b1;
		evictIndex = idx;
		@(posedge core_clk);
		@(negedge core_clk);
		evictValid = 1'b0;
	endtask
	task automatic arm(input cct_idx_t idx);
		@(negedge core_clk);
		stcArmValid = 1'b1;
		stcArmIndex = idx;
		@(negedge core_clk);
		stcArmValid = 1'b0;
	endtask
	// way bit appears one cycle after the taking edge
	task automatic alloc(input logic [1:0] way, input cct_idx_t idx);
		@(negedge core_clk);
		l1AllocValid = 1'b1;
		l1AllocWay = way;
		l1AllocIndex = idx;
		@(negedge core_clk);
		l1AllocValid = 1'b0;
		@(negedge core_clk);
	endtask
	// ==========================================
	// scenarios
	task automatic t_fills();
		for (int c = 0; c < 5; c++) begin
			sys.resp(3'h0, cct_code_t'(c), 32'h1234_5600 + c, c);
			check(respDone, 1'b1);
			check(respState, (c == 4) ? `CCT_TAG_INVALID : fill_tag(c));
			peek(3'h0);
			check(lookupData, (c == 4) ? `CCT_DATA_ONES : 32'h1234_5600 + c);
			check(lookupState, (c == 4) ? `CCT_TAG_INVALID : fill_tag(c));
		end
	endtask
	task automatic t_probes();
		for (int p = 0; p < 4; p++) begin
			for (int c = 0; c < 8; c++) begin
				sys.resp(3'h1, cct_code_t'(p), 32'h0000_00A0, 0);
				sys.probe(3'h1, cct_code_t'(c), c % 3);
				check(probeDone, 1'b1);
				check(probeHit, 1'b1);
				check(probeState, probe_tag(fill_tag(p), c));
				peek(3'h1);
				check(lookupState, probe_tag(fill_tag(p), c));
			end
		end
		// a block that was never filled misses and stays empty
		sys.probe(3'h6, 3'h1, 0);
		check(probeHit, 1'b0);
		check(probeState, `CCT_TAG_INVALID);
	endtask
	task automatic t_store_evict();
		logic [2:0] t;
		for (int c = 0; c < 4; c++) begin
			t = fill_tag(c);
			sys.resp(3'h2, cct_code_t'(c), 32'h0000_0B00, 1);
			store(3'h2, 32'h0000_0C00);
			check({storeGrant, storeDeny}, (t == `CCT_TAG_DIRTY) ? 2'h2 : 2'h1);
			evict(3'h2);
			check(evictDone, 1'b1);
			check(writebackValid, t[1]);
			check(writebackData, (t == `CCT_TAG_DIRTY) ? 32'h0000_0C00 : 32'h0000_0B00);
			peek(3'h2);
			check(lookupState, `CCT_TAG_INVALID);
		end
	endtask
	task automatic t_ownership();
		sys.resp(3'h3, 3'h0, 32'h0000_0D00, 0);
		arm(3'h3);
		sys.resp(3'h3, 3'h6, 32'h0000_0000, 2);
		check({stcFail, stcPass}, 2'h2);
		check(respState, `CCT_TAG_CLEAN);
		arm(3'h3);
		sys.resp(3'h3, 3'h5, 32'h0000_0000, 0);
		check({stcFail, stcPass}, 2'h1);
		check(respState, `CCT_TAG_DIRTY);
		sys.resp(3'h3, 3'h3, 32'h0000_0000, 0);
		sys.resp(3'h3, 3'h5, 32'h0000_0000, 0);
		check(respState, `CCT_TAG_DIRTY);
		sys.resp(3'h3, 3'h7, 32'h0000_0000, 0);
		check(respDone, 1'b1);
		check(respState, `CCT_TAG_DIRTY);
	endtask
	task automatic t_subset();
		sys.resp(3'h4, 3'h0, 32'h0000_0E00, 0);
		alloc(2'h2, 3'h4);
		check(l1Valid, 4'h4);
		evict(3'h4);
		@(negedge core_clk);
		check(l1Valid, 4'h0);
		alloc(2'h0, 3'h4);
		check(l1Valid, 4'h0);
		sys.resp(3'h5, 3'h1, 32'h0000_0F00, 0);
		alloc(2'h1, 3'h5);
		check(l1Valid, 4'h2);
		sys.probe(3'h5, 3'h4, 0);
		@(negedge core_clk);
		check(l1Valid, 4'h0);
	endtask
	// ==========================================
	// main sequence
	initial begin
		repeat (20) @(posedge core_clk);
		@(negedge core_clk);
		check(lookupState, `CCT_TAG_INVALID);
		check(l1Valid, 4'h0);
		arst_n = 1'b1;
		t_fills();
		t_probes();
		t_store_evict();
		t_ownership();
		t_subset();
		tally_and_finish();
	end
endmodule
